// ===== rtl/scr_pkg.sv
// system control clock register slice: offsets, fields, reset values
// assumes a classic wishbone slave on ref_clk with synchronous rst
// How it works
// - pad controls freeze while latch bit is 0, follow when 1; resets 1
// - ram order field places first three data rams in four orders
// - fourth, fifth data ram and cache ram keep fixed slots
// - three-bit alias field picks memory at address zero, seven codes
// - status shows up/down pairs per power domain; down flags reset 1
// - trim done reads 1 when applied trim equals target; resets 1
// - read-only flag shows an attached debugger; resets 0
// - slow rc enable resets 1; its trim resets to 0111
// - slow crystal bias current field, 0000 min, 1111 max, reset 0011
// - slow crystal bias resistor resets 2; crystal enable resets 0
// - fast crystal amplitude limited to 101, resets 3
// - fast crystal start-up current limited to 110, resets 0
// - fast crystal high-pass enable and spike bypass reset 0
// - fast rc enable at bit 0 and trim at 4:1 reset 0
// - low-frequency rc fields reset: on 0, low 0, bias 1, temp 7, trim 8
package scr_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [31:0] BLK_BASE     = 32'h5000_0000;
    localparam logic [31:0] OFS_SYS_CTRL = 32'h5000_0012;
    localparam logic [31:0] OFS_SYS_STAT = 32'h5000_0014;
    localparam logic [31:0] OFS_SLOW_OSC = 32'h5000_0020;
    localparam logic [31:0] OFS_FAST_OSC = 32'h5000_0022;
    localparam logic [31:0] OFS_LF_RC    = 32'h5000_0024;
    localparam int          IDX_W        = 8;
    localparam int          ADR_W        = 10;
    localparam int          WORD_LSB     = 2;
    localparam logic [IDX_W-1:0] IDX_SYS_CTRL = 8'(OFS_SYS_CTRL - BLK_BASE);
    localparam logic [IDX_W-1:0] IDX_SYS_STAT = 8'(OFS_SYS_STAT - BLK_BASE);
    localparam logic [IDX_W-1:0] IDX_SLOW_OSC = 8'(OFS_SLOW_OSC - BLK_BASE);
    localparam logic [IDX_W-1:0] IDX_FAST_OSC = 8'(OFS_FAST_OSC - BLK_BASE);
    localparam logic [IDX_W-1:0] IDX_LF_RC    = 8'(OFS_LF_RC - BLK_BASE);

    // ------------------------------------------------------------------
    // widths, masks and reset words
    // ------------------------------------------------------------------
    localparam int          REG_W       = 16;
    localparam int          PAD_W       = 16;
    localparam int          TRIM_W      = 8;
    localparam int          SYNC_W      = 7;
    localparam logic [15:0] SYS_CTRL_WM = 16'h043F;
    localparam logic [15:0] SYS_CTRL_RV = 16'h0020;
    localparam logic [15:0] SLOW_WM     = 16'h1FFF;
    localparam logic [15:0] SLOW_RV     = 16'h079C;
    localparam logic [15:0] FAST_WM     = 16'h7CFF;
    localparam logic [15:0] FAST_RV     = 16'h0C00;
    localparam logic [15:0] LF_WM       = 16'h0FFF;
    localparam logic [15:0] LF_RV       = 16'h0178;
    localparam logic [15:0] STAT_FIXED  = 16'h0400;
    localparam logic [PAD_W-1:0] PAD_RV = 16'h0000;
    // sync order: debugger, dbg on/off, periph on/off, radio on/off
    localparam logic [6:0]  SYNC_RV     = 7'h15;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int SC_CACHE_VIS = 10;
    localparam int SC_PAD_LATCH = 5;
    localparam int SC_ORDER_LO  = 3;
    localparam int SC_ALIAS_LO  = 0;
    localparam int ST_DBG_ON    = 9;
    localparam int ST_DBG_OFF   = 8;
    localparam int ST_TRIM_DONE = 6;
    localparam int ST_DEBUGGER  = 5;
    localparam int ST_PER_ON    = 3;
    localparam int ST_PER_OFF   = 2;
    localparam int ST_RAD_ON    = 1;
    localparam int ST_RAD_OFF   = 0;
    localparam int SO_AMP_OFF   = 12;
    localparam int SO_RC_TRIM   = 8;
    localparam int SO_RC_ON     = 7;
    localparam int SO_CUR       = 3;
    localparam int SO_RBIAS     = 1;
    localparam int SO_XTAL_ON   = 0;
    localparam int FO_HPASS     = 14;
    localparam int FO_SPIKE     = 13;
    localparam int FO_AMP       = 10;
    localparam int FO_CUR       = 5;
    localparam int FO_RC_TRIM   = 1;
    localparam int FO_RC_ON     = 0;
    localparam int LF_ON        = 11;
    localparam int LF_LOW       = 10;
    localparam int LF_BIAS      = 8;
    localparam int LF_TEMP      = 4;
    localparam int LF_TRIM      = 0;

    // ------------------------------------------------------------------
    // codes and limits
    // ------------------------------------------------------------------
    localparam logic [2:0] AMP_MAX      = 3'h5;
    localparam logic [2:0] CUR_MAX      = 3'h6;
    localparam logic [2:0] ALIAS_CACHE  = 3'h6;
    localparam logic [2:0] SLOT_DRAM4   = 3'h3;
    localparam logic [2:0] SLOT_DRAM5   = 3'h4;
    localparam logic [2:0] SLOT_CACHE   = 3'h5;
    localparam logic [6:0] ALIAS_NONE   = 7'h00;

    // byte-lane merge of a write into the writable bits only
    function automatic logic [15:0] wr_merge(input logic [15:0] old,
                                             input logic [15:0] wdat,
                                             input logic [1:0]  sel,
                                             input logic [15:0] wm);
        logic [15:0] lane;
        lane = {{8{sel[1]}}, {8{sel[0]}}} & wm;
        return (old & ~lane) | (wdat & lane);
    endfunction : wr_merge

    function automatic logic [2:0] clamp3(input logic [2:0] v,
                                          input logic [2:0] lim);
        return (v > lim) ? lim : v;
    endfunction : clamp3

endpackage : scr_pkg

// ===== rtl/scr_sync.sv
// two-flop synchroniser for a group of independent level flags
// assumes each bit is a slow level from another power or clock domain
`timescale 1ns/1ns
module scr_sync #(
    parameter int              WIDTH  = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // ------------------------------------------------------------------
    // first stage feeds only the second
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            stage1   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule : scr_sync

// ===== rtl/scr_regs.sv
// system control clock register slice with a classic wishbone slave
// assumes power-domain and debugger flags arrive from other domains,
// pad controls and applied trim come from logic on ref_clk
`timescale 1ns/1ns
module scr_regs
    import scr_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              wb_cyc,
    input  wire logic              wb_stb,
    input  wire logic              wb_we,
    input  wire logic [ADR_W-1:0]  wb_adr,
    input  wire logic [3:0]        wb_sel,
    input  wire logic [31:0]       wb_dat_w,
    output logic      [31:0]       wb_dat_r,
    output logic                   wb_ack,
    input  wire logic [PAD_W-1:0]  pad_ctrl_in,
    output logic      [PAD_W-1:0]  pad_ctrl_out,
    output logic      [2:0]        dram1_slot,
    output logic      [2:0]        dram2_slot,
    output logic      [2:0]        dram3_slot,
    output logic      [2:0]        dram4_slot,
    output logic      [2:0]        dram5_slot,
    output logic      [2:0]        cache_slot,
    output logic      [6:0]        boot_alias_onehot,
    output logic                   cache_ram_visibility,
    input  wire logic              dbg_domain_on,
    input  wire logic              dbg_domain_off,
    input  wire logic              periph_domain_on,
    input  wire logic              periph_domain_off,
    input  wire logic              radio_domain_on,
    input  wire logic              radio_domain_off,
    input  wire logic              debugger_attached,
    input  wire logic [TRIM_W-1:0] crystal_trim_target,
    input  wire logic [TRIM_W-1:0] crystal_trim_applied,
    output logic                   slow_crystal_amp_reg_off,
    output logic      [3:0]        slow_rc_trim,
    output logic                   slow_rc_on,
    output logic      [3:0]        slow_crystal_bias_current,
    output logic      [1:0]        slow_crystal_bias_resistor,
    output logic                   slow_crystal_on,
    output logic                   fast_crystal_highpass_on,
    output logic                   fast_crystal_spike_bypass,
    output logic      [2:0]        fast_crystal_amplitude,
    output logic      [2:0]        fast_crystal_startup_current,
    output logic      [3:0]        fast_rc_trim,
    output logic                   fast_rc_on,
    output logic                   lowfreq_rc_on,
    output logic                   lowfreq_rc_extra_low,
    output logic      [1:0]        lowfreq_rc_bias,
    output logic      [3:0]        lowfreq_rc_temp_ctrl,
    output logic      [3:0]        lowfreq_rc_trim
);

    // ------------------------------------------------------------------
    // storage and local decode
    // ------------------------------------------------------------------
    logic [REG_W-1:0]  sys_ctrl;
    logic [REG_W-1:0]  slow_osc;
    logic [REG_W-1:0]  fast_osc;
    logic [REG_W-1:0]  lf_osc;
    logic              trim_done;
    logic [SYNC_W-1:0] flag_sync;
    logic [IDX_W-1:0]  idx;
    logic              bus_req;
    logic              wr_req;
    logic [1:0]        ram_order;
    logic [2:0]        alias_code;
    logic [REG_W-1:0]  stat_word;
    logic [REG_W-1:0]  next_rdata;

    assign idx        = wb_adr[ADR_W-1:WORD_LSB];
    assign bus_req    = wb_cyc && wb_stb && !wb_ack;
    assign wr_req     = bus_req && wb_we;
    assign ram_order  = sys_ctrl[SC_ORDER_LO +: 2];
    assign alias_code = sys_ctrl[SC_ALIAS_LO +: 3];

    // slot of each of the first three data rams, packed {r1, r2, r3}
    function automatic logic [8:0] order_slots(input logic [1:0] ord);
        case (ord)
            2'h0:    return {3'h0, 3'h1, 3'h2};
            2'h1:    return {3'h1, 3'h0, 3'h2};
            2'h2:    return {3'h1, 3'h2, 3'h0};
            default: return {3'h2, 3'h1, 3'h0};
        endcase
    endfunction : order_slots

    // one-hot memory at address zero; unused code selects none
    function automatic logic [6:0] alias_decode(input logic [2:0] code);
        if (code > ALIAS_CACHE) begin
            return ALIAS_NONE;
        end else begin
            return 7'(7'h01 << code);
        end
    endfunction : alias_decode

    // ------------------------------------------------------------------
    // status flag synchronisers
    // ------------------------------------------------------------------
    scr_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (SYNC_RV)
    ) u_flag_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({debugger_attached, dbg_domain_on, dbg_domain_off,
                    periph_domain_on, periph_domain_off,
                    radio_domain_on, radio_domain_off}),
        .sync_out (flag_sync)
    );

    // ------------------------------------------------------------------
    // wishbone handshake
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_ack <= 1'b0;
        end else begin
            wb_ack <= bus_req;
        end
    end

    // status word: fixed reserved bits, synced flags, trim compare
    always_comb begin
        stat_word               = STAT_FIXED;
        stat_word[ST_DEBUGGER]  = flag_sync[6];
        stat_word[ST_DBG_ON]    = flag_sync[5];
        stat_word[ST_DBG_OFF]   = flag_sync[4];
        stat_word[ST_PER_ON]    = flag_sync[3];
        stat_word[ST_PER_OFF]   = flag_sync[2];
        stat_word[ST_RAD_ON]    = flag_sync[1];
        stat_word[ST_RAD_OFF]   = flag_sync[0];
        stat_word[ST_TRIM_DONE] = trim_done;
    end

    // read mux; unmapped words read as zero
    always_comb begin
        if (idx == IDX_SYS_CTRL) begin
            next_rdata = sys_ctrl;
        end else if (idx == IDX_SYS_STAT) begin
            next_rdata = stat_word;
        end else if (idx == IDX_SLOW_OSC) begin
            next_rdata = slow_osc;
        end else if (idx == IDX_FAST_OSC) begin
            next_rdata = fast_osc;
        end else if (idx == IDX_LF_RC) begin
            next_rdata = lf_osc;
        end else begin
            next_rdata = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wb_dat_r <= '0;
        end else if (bus_req && !wb_we) begin
            wb_dat_r <= {16'h0000, next_rdata};
        end
    end

    // ------------------------------------------------------------------
    // writable registers; only masked bits accept writes
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sys_ctrl <= SYS_CTRL_RV;
        end else if (wr_req && idx == IDX_SYS_CTRL) begin
            sys_ctrl <= wr_merge(sys_ctrl, wb_dat_w[15:0], wb_sel[1:0],
                                 SYS_CTRL_WM);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slow_osc <= SLOW_RV;
        end else if (wr_req && idx == IDX_SLOW_OSC) begin
            slow_osc <= wr_merge(slow_osc, wb_dat_w[15:0], wb_sel[1:0],
                                 SLOW_WM);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fast_osc <= FAST_RV;
        end else if (wr_req && idx == IDX_FAST_OSC) begin
            fast_osc <= wr_merge(fast_osc, wb_dat_w[15:0], wb_sel[1:0],
                                 FAST_WM);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lf_osc <= LF_RV;
        end else if (wr_req && idx == IDX_LF_RC) begin
            lf_osc <= wr_merge(lf_osc, wb_dat_w[15:0], wb_sel[1:0], LF_WM);
        end
    end

    // ------------------------------------------------------------------
    // trim compare and pad latch
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trim_done <= 1'b1;
        end else begin
            trim_done <=
                (crystal_trim_applied == crystal_trim_target);
        end
    end

    // closed latch keeps the last pad controls for retention
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pad_ctrl_out <= PAD_RV;
        end else if (sys_ctrl[SC_PAD_LATCH]) begin
            pad_ctrl_out <= pad_ctrl_in;
        end
    end

    // ------------------------------------------------------------------
    // memory map outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            {dram1_slot, dram2_slot, dram3_slot} <= order_slots(2'h0);
        end else begin
            {dram1_slot, dram2_slot, dram3_slot} <=
                order_slots(ram_order);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dram4_slot <= SLOT_DRAM4;
            dram5_slot <= SLOT_DRAM5;
            cache_slot <= SLOT_CACHE;
        end else begin
            dram4_slot <= SLOT_DRAM4;
            dram5_slot <= SLOT_DRAM5;
            cache_slot <= SLOT_CACHE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            boot_alias_onehot <= alias_decode(3'h0);
        end else begin
            boot_alias_onehot <= alias_decode(alias_code);
        end
    end

    // ------------------------------------------------------------------
    // oscillator controls
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fast_crystal_amplitude       <= FAST_RV[FO_AMP +: 3];
            fast_crystal_startup_current <= FAST_RV[FO_CUR +: 3];
        end else begin
            fast_crystal_amplitude <=
                clamp3(fast_osc[FO_AMP +: 3], AMP_MAX);
            fast_crystal_startup_current <=
                clamp3(fast_osc[FO_CUR +: 3], CUR_MAX);
        end
    end

    assign cache_ram_visibility       = sys_ctrl[SC_CACHE_VIS];
    assign slow_crystal_amp_reg_off   = slow_osc[SO_AMP_OFF];
    assign slow_rc_trim               = slow_osc[SO_RC_TRIM +: 4];
    assign slow_rc_on                 = slow_osc[SO_RC_ON];
    assign slow_crystal_bias_current  = slow_osc[SO_CUR +: 4];
    assign slow_crystal_bias_resistor = slow_osc[SO_RBIAS +: 2];
    assign slow_crystal_on            = slow_osc[SO_XTAL_ON];
    assign fast_crystal_highpass_on   = fast_osc[FO_HPASS];
    assign fast_crystal_spike_bypass  = fast_osc[FO_SPIKE];
    assign fast_rc_trim               = fast_osc[FO_RC_TRIM +: 4];
    assign fast_rc_on                 = fast_osc[FO_RC_ON];
    assign lowfreq_rc_on              = lf_osc[LF_ON];
    assign lowfreq_rc_extra_low       = lf_osc[LF_LOW];
    assign lowfreq_rc_bias            = lf_osc[LF_BIAS +: 2];
    assign lowfreq_rc_temp_ctrl       = lf_osc[LF_TEMP +: 4];
    assign lowfreq_rc_trim            = lf_osc[LF_TRIM +: 4];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_stat_read;
        bus_req && !wb_we && idx == IDX_SYS_STAT;
    endsequence

    sequence s_order_held(logic [1:0] v);
        (ram_order == v) [*2];
    endsequence

    chk_ack_one_cycle: assert property (
        bus_req |=> wb_ack ##1 !wb_ack)
        else $error("ack not a single cycle pulse");
    chk_pad_hold: assert property (
        !sys_ctrl[SC_PAD_LATCH] |=> $stable(pad_ctrl_out))
        else $error("pad controls moved while latched");
    chk_pad_pass: assert property (
        sys_ctrl[SC_PAD_LATCH] |=> pad_ctrl_out == $past(pad_ctrl_in))
        else $error("pad controls not passed through");
    chk_order_three: assert property (
        s_order_held(2'h2) |->
        dram3_slot == 3'h0 && dram1_slot == 3'h1 && dram2_slot == 3'h2)
        else $error("ram order 2 slots wrong");
    chk_fixed_slots: assert property (
        dram4_slot == SLOT_DRAM4 && dram5_slot == SLOT_DRAM5 &&
        cache_slot == SLOT_CACHE)
        else $error("fixed ram slot moved");
    chk_alias_cache: assert property (
        (alias_code == ALIAS_CACHE) [*2] |-> boot_alias_onehot == 7'h40)
        else $error("cache alias not selected");
    chk_trim_match: assert property (
        (crystal_trim_applied == crystal_trim_target) [*2] |->
        stat_word[ST_TRIM_DONE])
        else $error("trim done not shown");
    chk_debugger_seen: assert property (
        debugger_attached [*3] |-> stat_word[ST_DEBUGGER])
        else $error("debugger flag missing");
    chk_stat_fixed: assert property (
        s_stat_read |=> wb_dat_r[10] && !wb_dat_r[11] && !wb_dat_r[7])
        else $error("reserved status bits wrong");
    chk_ro_bits: assert property (
        (sys_ctrl & ~SYS_CTRL_WM) == 16'h0000 &&
        (fast_osc & ~FAST_WM) == 16'h0000)
        else $error("read-only bits changed");
    chk_amp_limit: assert property (
        fast_crystal_amplitude <= AMP_MAX &&
        fast_crystal_startup_current <= CUR_MAX)
        else $error("fast crystal limit exceeded");
    chk_reset_words: assert property (
        $past(rst) |-> slow_osc == SLOW_RV && lf_osc == LF_RV &&
        fast_osc == FAST_RV && sys_ctrl == SYS_CTRL_RV)
        else $error("reset value wrong");
    chk_down_reset: assert property (
        $past(rst) |-> flag_sync == SYNC_RV)
        else $error("domain flags reset wrong");

endmodule : scr_regs

// ===== dv/scr_tb.sv
// self-checking bench for the system control clock register slice
// assumes scr_regs acks one cycle after taking a wishbone request
`timescale 1ns/1ns
module testbench;
    import scr_pkg::*;
    logic        ref_clk, rst, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [9:0]  wb_adr;
    logic [3:0]  wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, q;
    logic [15:0] pad_in, pad_out;
    logic [2:0]  s1, s2, s3, s4, s5, sc, amp, cur;
    logic [6:0]  oh, dom;
    logic [7:0]  tgt, app;
    wire  [12:0] so_o;
    wire  [11:0] lf_o;
    wire  [6:0]  fo_o;
    wire         vis;
    int          fails, n_tests, cyc_n;

    scr_regs u_scr_regs (.ref_clk(ref_clk), .rst(rst), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .pad_ctrl_in(pad_in), .pad_ctrl_out(pad_out), .dram1_slot(s1),
        .dram2_slot(s2), .dram3_slot(s3), .dram4_slot(s4), .dram5_slot(s5),
        .cache_slot(sc), .boot_alias_onehot(oh), .cache_ram_visibility(vis),
        .debugger_attached(dom[6]), .dbg_domain_on(dom[5]),
        .dbg_domain_off(dom[4]), .periph_domain_on(dom[3]),
        .periph_domain_off(dom[2]), .radio_domain_on(dom[1]),
        .radio_domain_off(dom[0]), .crystal_trim_target(tgt),
        .crystal_trim_applied(app), .slow_crystal_amp_reg_off(so_o[12]),
        .slow_rc_trim(so_o[11:8]), .slow_rc_on(so_o[7]),
        .slow_crystal_bias_current(so_o[6:3]),
        .slow_crystal_bias_resistor(so_o[2:1]), .slow_crystal_on(so_o[0]),
        .fast_crystal_highpass_on(fo_o[6]),
        .fast_crystal_spike_bypass(fo_o[5]),
        .fast_crystal_amplitude(amp), .fast_crystal_startup_current(cur),
        .fast_rc_trim(fo_o[4:1]), .fast_rc_on(fo_o[0]),
        .lowfreq_rc_on(lf_o[11]), .lowfreq_rc_extra_low(lf_o[10]),
        .lowfreq_rc_bias(lf_o[9:8]), .lowfreq_rc_temp_ctrl(lf_o[7:4]),
        .lowfreq_rc_trim(lf_o[3:0]));

    // ------------------------------------------------------------
    // bus, compare and closing tasks
    // ------------------------------------------------------------
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] got, exp, input string m);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [15:0] d, input logic [3:0] s = 4'h3);
        @(posedge ref_clk);
        wb_cyc <= 1; wb_stb <= 1; wb_we <= w; wb_adr <= a;
        wb_dat_w <= {16'h0000, d};
        wb_sel <= s;
        do @(posedge ref_clk); while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 0; wb_stb <= 0; wb_we <= 0;
    endtask : bus

    task automatic rdchk(input logic [9:0] a, input logic [15:0] e);
        bus(0, a, 16'h0000);
        chk(q, {16'h0000, e}, "read");
    endtask : rdchk

    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_n

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rdchk(10'h048, 16'h0020);
        rdchk(10'h050, 16'h0545);
        rdchk(10'h080, 16'h079C);
        rdchk(10'h088, 16'h0C00);
        rdchk(10'h090, 16'h0178);
        chk(so_o, SLOW_RV[12:0], "slow");
        chk(fo_o, 7'h00, "fast");
        chk(lf_o, LF_RV[11:0], "lowfreq");
    endtask : t_reset

    task automatic t_write;
        bus(1, 10'h080, 16'hFFFF);
        rdchk(10'h080, 16'h1FFF);
        chk(so_o, 13'h1FFF, "slow");
        bus(1, 10'h088, 16'hFFFF);
        rdchk(10'h088, 16'h7CFF);
        chk(fo_o, 7'h7F, "fast");
        wait_n(2);
        chk({amp, cur}, {3'h5, 3'h6}, "clamp");
        bus(1, 10'h090, 16'hFFFF);
        rdchk(10'h090, 16'h0FFF);
        chk(lf_o, 12'hFFF, "lowfreq");
        bus(1, 10'h090, 16'h0000, 4'h2);
        rdchk(10'h090, 16'h00FF);
        bus(1, 10'h050, 16'hFFFF);
        rdchk(10'h050, 16'h0545);
        bus(1, 10'h3FC, 16'hFFFF);
        rdchk(10'h3FC, 16'h0000);
        bus(1, 10'h048, 16'hFFFF);
        rdchk(10'h048, 16'h043F);
        chk(vis, 1'b1, "cache visible");
    endtask : t_write

    task automatic t_pad;
        pad_in <= 16'hA5C3;
        wait_n(3);
        chk(pad_out, 16'hA5C3, "pad follow");
        bus(1, 10'h048, 16'h0000);
        pad_in <= 16'h3C5A;
        wait_n(3);
        chk(pad_out, 16'hA5C3, "pad hold");
        bus(1, 10'h048, 16'h0020);
        wait_n(3);
        chk(pad_out, 16'h3C5A, "pad release");
    endtask : t_pad

    task automatic t_map;
        logic [8:0] ord [4] = '{9'o012, 9'o102, 9'o120, 9'o210};
        for (int i = 0; i < 8; i++) begin
            bus(1, 10'h048,
                16'h0020 | 16'(i[1:0]) << 3 | 16'(i));
            wait_n(2);
            chk({s1, s2, s3}, ord[i[1:0]], "ram order");
            chk({s4, s5, sc}, 9'o345, "fixed slots");
            chk(oh, i < 7 ? 7'(1 << i) : 7'h00, "alias");
            chk(vis, 1'b0, "cache visible");
        end
    endtask : t_map

    task automatic t_status;
        dom <= 7'h6A;
        tgt <= 8'h11;
        wait_n(4);
        rdchk(10'h050, 16'h062A);
        app <= 8'h11;
        wait_n(4);
        rdchk(10'h050, 16'h066A);
    endtask : t_status

    always #5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n > 3000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        ref_clk = 0; rst = 1; wb_cyc = 0; wb_stb = 0; wb_we = 0;
        wb_adr = '0; wb_sel = 4'h3; wb_dat_w = '0; pad_in = 16'h0000;
        dom = 7'h15; tgt = 8'h00; app = 8'h00;
        fails = 0; n_tests = 0;
        wait_n(4);
        rst <= 0;
        wait_n(4);
        t_reset();
        t_pad();
        t_map();
        t_write();
        t_status();
        conclude();
    end
endmodule : testbench
